// file: hdl/dcp_pkg.sv
// constants and types of the nine-channel dma transfer parameter block
// Notes on behaviour
// - each channel has a read/write source address at base plus 0x04, reset zero
// - source address is a full 32-bit field giving where data is fetched
// - each channel has a read/write destination address at base plus 0x08, reset zero
// - destination address is a full 32-bit field giving where data is written
// - each channel has a read/write byte count at base plus 0x0C, reset zero
// - byte count sits in bits 15..0; bits 31..16 reserved, read zero
// - source step select 00 advances the source address, 10 holds it
// - destination step select 00 advances the destination address, 10 holds it
// - hardware clears the trigger bit when the programmed transfer completes
// - soft reset of the served channel clears engine, remaining counts and buffer; its write still loads enable and step selects; self-clears
package dcp_pkg;

  localparam int          NUM_CH      = 9;
  localparam int          WORD_W      = 32;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          CH_SEL_LSB  = 8;
  localparam logic [3:0]  NUM_CH_4    = 4'h9;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_SRC     = 8'h04;
  localparam logic [7:0]  OFF_DST     = 8'h08;
  localparam logic [7:0]  OFF_CNT     = 8'h0C;
  localparam int          BIT_EN      = 0;
  localparam int          BIT_SRST    = 1;
  localparam int          SRC_STEP_LSB = 4;
  localparam int          DST_STEP_LSB = 6;
  localparam int          BIT_TRIG    = 23;
  localparam logic [1:0]  STEP_INC    = 2'h0;
  localparam logic [1:0]  STEP_FIX    = 2'h2;
  localparam logic [31:0] RST_ADDR    = 32'h0000_0000;
  localparam logic [15:0] RST_CNT     = 16'h0000;
  localparam logic [15:0] UNIT_BYTES  = 16'h0004;
  localparam logic [31:0] UNIT_STEP   = 32'h0000_0004;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PICK  = 2'b01,
    ST_READ  = 2'b10,
    ST_WRITE = 2'b11
  } dcp_state_t;

  typedef struct packed {
    logic       trig;
    logic [1:0] dst_step_select;
    logic [1:0] src_step_select;
    logic       en;
  } dcp_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcp_bus_cmd_t;

  localparam dcp_ctrl_t RST_CTRL = '{trig: 1'b0, dst_step_select: 2'h0,
                                     src_step_select: 2'h0, en: 1'b0};
  localparam dcp_bus_cmd_t RST_CMD = '{valid: 1'b0, we: 1'b0,
                                       addr: 32'h0000_0000, wdata: 32'h0000_0000};

endpackage : dcp_pkg

// file: hdl/dcp_top.sv
// word fifo and the dma channel parameter block with its transfer engine
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module dcp_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  // honest full and empty from the fill count
  assign in_ready  = (cnt_q != (AW + 1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // pointers and count, cleared by reset or flush
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= next_ptr(wr_ptr_q);
      if (pop)
        rd_ptr_q <= next_ptr(rd_ptr_q);
      if (push && !pop)
        cnt_q <= cnt_q + (AW + 1)'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - (AW + 1)'(1);
    end
  end

endmodule : dcp_fifo

module dcp_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  output dcp_pkg::dcp_bus_cmd_t     bus_cmd,
  input  wire logic                 bus_ack,
  input  wire logic [31:0]          bus_rdata,
  output logic                      busy,
  output logic                      xfer_done
);
  dcp_pkg::dcp_ctrl_t    ctrl_q [dcp_pkg::NUM_CH];
  logic [31:0]           src_q  [dcp_pkg::NUM_CH];
  logic [31:0]           dst_q  [dcp_pkg::NUM_CH];
  logic [15:0]           cnt_q  [dcp_pkg::NUM_CH];
  dcp_pkg::dcp_state_t   state_q;
  logic [3:0]            ch_q;
  logic [31:0]           cur_src_q;
  logic [31:0]           cur_dst_q;
  logic [15:0]           rd_left_q;
  logic [15:0]           wr_left_q;
  logic [31:0]           rdata_q;
  dcp_pkg::dcp_bus_cmd_t cmd_q;
  logic                  busy_q;
  logic                  done_q;
  logic [3:0]            acc_ch;
  logic [7:0]            acc_off;
  logic                  acc_hit;
  logic                  srst_hit;
  logic                  abort;
  logic                  finish;
  logic                  pick_any;
  logic [3:0]            pick_ch;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [31:0]           fifo_out_data;
  logic                  fifo_push;
  logic                  fifo_pop;
  logic                  fifo_flush;

  // next working address for one unit under a step select
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] sel);
    step_addr = (sel == dcp_pkg::STEP_FIX) ? a : a + dcp_pkg::UNIT_STEP;
  endfunction : step_addr

  // control word as software sees it; soft reset bit always reads zero
  function automatic logic [31:0] ctrl_word(input dcp_pkg::dcp_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[dcp_pkg::BIT_TRIG] = c.trig;
    w[dcp_pkg::DST_STEP_LSB +: 2] = c.dst_step_select;
    w[dcp_pkg::SRC_STEP_LSB +: 2] = c.src_step_select;
    w[dcp_pkg::BIT_EN] = c.en;
    ctrl_word = w;
  endfunction : ctrl_word

  // address split into channel and register offset
  assign acc_ch  = reg_addr[11:dcp_pkg::CH_SEL_LSB];
  assign acc_off = reg_addr[dcp_pkg::CH_SEL_LSB-1:0];
  assign acc_hit = (acc_ch < dcp_pkg::NUM_CH_4);

  // soft reset strobe for the channel the engine is serving
  assign srst_hit = reg_wr && acc_hit && (acc_off == dcp_pkg::OFF_CTRL)
                    && reg_wdata[dcp_pkg::BIT_SRST] && (acc_ch == ch_q)
                    && (state_q != dcp_pkg::ST_IDLE);
  assign abort    = (state_q == dcp_pkg::ST_PICK) && !ctrl_q[ch_q].en;
  assign finish   = (state_q == dcp_pkg::ST_PICK) && ctrl_q[ch_q].en
                    && (wr_left_q == 16'h0000) && !srst_hit;

  // lowest-numbered enabled and triggered channel wins the engine
  always_comb
  begin
    pick_any = 1'b0;
    pick_ch  = 4'h0;
    for (int i = dcp_pkg::NUM_CH - 1; i >= 0; i--)
    begin
      if (ctrl_q[i].en && ctrl_q[i].trig)
      begin
        pick_any = 1'b1;
        pick_ch  = 4'(i);
      end
    end
  end

  // programmed parameters, written only by software
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < dcp_pkg::NUM_CH; i++)
      begin
        src_q[i] <= dcp_pkg::RST_ADDR;
        dst_q[i] <= dcp_pkg::RST_ADDR;
        cnt_q[i] <= dcp_pkg::RST_CNT;
      end
    end
    else if (reg_wr && acc_hit)
    begin
      if (acc_off == dcp_pkg::OFF_SRC)
        src_q[acc_ch] <= reg_wdata;
      else if (acc_off == dcp_pkg::OFF_DST)
        dst_q[acc_ch] <= reg_wdata;
      else if (acc_off == dcp_pkg::OFF_CNT)
        cnt_q[acc_ch] <= reg_wdata[15:0];
    end
  end

  // control fields; a software set of the trigger beats the hardware clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < dcp_pkg::NUM_CH; i++)
      begin
        ctrl_q[i] <= dcp_pkg::RST_CTRL;
      end
    end
    else
    begin
      if (finish)
        ctrl_q[ch_q].trig <= 1'b0;
      if (reg_wr && acc_hit && (acc_off == dcp_pkg::OFF_CTRL))
      begin
        ctrl_q[acc_ch].en              <= reg_wdata[dcp_pkg::BIT_EN];
        ctrl_q[acc_ch].src_step_select <= reg_wdata[dcp_pkg::SRC_STEP_LSB +: 2];
        ctrl_q[acc_ch].dst_step_select <= reg_wdata[dcp_pkg::DST_STEP_LSB +: 2];
        if (reg_wdata[dcp_pkg::BIT_TRIG])
          ctrl_q[acc_ch].trig <= 1'b1;
      end
    end
  end

  // read data, valid in the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (reg_rd && acc_hit)
    begin
      if (acc_off == dcp_pkg::OFF_CTRL)
        rdata_q <= ctrl_word(ctrl_q[acc_ch]);
      else if (acc_off == dcp_pkg::OFF_SRC)
        rdata_q <= src_q[acc_ch];
      else if (acc_off == dcp_pkg::OFF_DST)
        rdata_q <= dst_q[acc_ch];
      else if (acc_off == dcp_pkg::OFF_CNT)
        rdata_q <= {16'h0000, cnt_q[acc_ch]};
      else
        rdata_q <= 32'h0000_0000; // unmapped offset
    end
    else
    begin
      rdata_q <= 32'h0000_0000; // unmapped channel or no read
    end
  end

  // engine sequencing: fetch into the fifo while it has room, else drain
  always_ff @(posedge clk)
  begin
    if (rst || srst_hit)
    begin
      state_q <= dcp_pkg::ST_IDLE;
      cmd_q   <= dcp_pkg::RST_CMD;
    end
    else
    begin
      case (state_q)
        dcp_pkg::ST_IDLE:
        begin
          if (pick_any)
          begin
            state_q <= dcp_pkg::ST_PICK;
          end
        end
        dcp_pkg::ST_PICK:
        begin
          if (abort || finish)
          begin
            state_q <= dcp_pkg::ST_IDLE;
          end
          else if ((rd_left_q != 16'h0000) && fifo_in_ready)
          begin
            cmd_q   <= '{valid: 1'b1, we: 1'b0, addr: cur_src_q, wdata: 32'h0000_0000};
            state_q <= dcp_pkg::ST_READ;
          end
          else if (fifo_out_valid)
          begin
            cmd_q   <= '{valid: 1'b1, we: 1'b1, addr: cur_dst_q, wdata: fifo_out_data};
            state_q <= dcp_pkg::ST_WRITE;
          end
        end
        dcp_pkg::ST_READ, dcp_pkg::ST_WRITE:
        begin
          if (bus_ack)
          begin
            cmd_q   <= dcp_pkg::RST_CMD;
            state_q <= dcp_pkg::ST_PICK;
          end
        end
        default:
        begin
          state_q <= dcp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // working copies of address and count, kept apart from the programmed values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ch_q      <= 4'h0;
      cur_src_q <= dcp_pkg::RST_ADDR;
      cur_dst_q <= dcp_pkg::RST_ADDR;
      rd_left_q <= dcp_pkg::RST_CNT;
      wr_left_q <= dcp_pkg::RST_CNT;
    end
    else if (srst_hit)
    begin
      rd_left_q <= dcp_pkg::RST_CNT;
      wr_left_q <= dcp_pkg::RST_CNT;
    end
    else if ((state_q == dcp_pkg::ST_IDLE) && pick_any)
    begin
      ch_q      <= pick_ch;
      cur_src_q <= src_q[pick_ch];
      cur_dst_q <= dst_q[pick_ch];
      rd_left_q <= cnt_q[pick_ch];
      wr_left_q <= cnt_q[pick_ch];
    end
    else if ((state_q == dcp_pkg::ST_READ) && bus_ack)
    begin
      cur_src_q <= step_addr(cur_src_q, ctrl_q[ch_q].src_step_select);
      rd_left_q <= rd_left_q - dcp_pkg::UNIT_BYTES;
    end
    else if ((state_q == dcp_pkg::ST_WRITE) && bus_ack)
    begin
      cur_dst_q <= step_addr(cur_dst_q, ctrl_q[ch_q].dst_step_select);
      wr_left_q <= wr_left_q - dcp_pkg::UNIT_BYTES;
    end
  end

  // status outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_q != dcp_pkg::ST_IDLE) && !srst_hit && !abort && !finish;
      done_q <= finish;
    end
  end

  // fifo traffic: fill on read answer, drain when a write is issued
  assign fifo_push  = (state_q == dcp_pkg::ST_READ) && bus_ack && !srst_hit;
  assign fifo_pop   = (state_q == dcp_pkg::ST_PICK) && !abort && !finish && !srst_hit
                      && !((rd_left_q != 16'h0000) && fifo_in_ready);
  assign fifo_flush = srst_hit || abort || finish;

  dcp_fifo #(
    .W (dcp_pkg::WORD_W),
    .D (dcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (fifo_flush),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (bus_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  assign reg_rdata = rdata_q;
  assign bus_cmd   = cmd_q;
  assign busy      = busy_q;
  assign xfer_done = done_q;

endmodule : dcp_top

`default_nettype wire

// file: sim/dcp_bus_model.sv
// system bus source and sink model with random ack delay
`timescale 1ns/1ps
`default_nettype none

module dcp_bus_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire dcp_pkg::dcp_bus_cmd_t bus_cmd,
  output var logic                   bus_ack,
  output var logic [31:0]            bus_rdata
);
  int unsigned wait_q;

  // one ack per command; read data line shows junk outside the ack cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      bus_ack   <= 1'b0;
      bus_rdata <= 32'h0;
      wait_q    <= 0;
    end
    else if (bus_ack)
    begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
      wait_q    <= $urandom % 4;
    end
    else if (bus_cmd.valid && wait_q == 0)
    begin
      bus_ack   <= 1'b1;
      bus_rdata <= ~bus_cmd.addr; // read returns inverted address
    end
    else if (bus_cmd.valid)
      wait_q <= wait_q - 1;
  end
endmodule : dcp_bus_model

`default_nettype wire

// file: sim/dcp_top_chk.sv
// port assertions for the dma channel parameter block
`timescale 1ns/1ps
`default_nettype none

module dcp_top_chk (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic [11:0]           reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire dcp_pkg::dcp_bus_cmd_t bus_cmd,
  input wire logic                  bus_ack,
  input wire logic [31:0]           bus_rdata,
  input wire logic                  busy,
  input wire logic                  xfer_done
);
  logic [3:0] fill_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // words fetched from the source and not yet written out; an idle engine holds none
  always_ff @(posedge clk)
  begin
    if (rst || !busy)
      fill_q <= 4'h0;
    else if (bus_cmd.valid && bus_ack)
      fill_q <= bus_cmd.we ? fill_q - 4'h1 : fill_q + 4'h1;
  end

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  unmapped_rd_a: assert property (reg_rd && (reg_addr[11:8] > 4'h8 || reg_addr[7:0] > 8'h0C)
    |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  count_hi_a: assert property (reg_rd && reg_addr[7:0] == 8'h0C |=> reg_rdata[31:16] == 16'h0)
    else $error("count upper half not zero");
  cmd_hold_a: assert property (bus_cmd.valid && !bus_ack
    && !(reg_wr && reg_addr[7:0] == 8'h00 && reg_wdata[1]) |=> $stable(bus_cmd))
    else $error("bus command changed before ack");
  cmd_drop_a: assert property (bus_cmd.valid && bus_ack |=> !bus_cmd.valid)
    else $error("bus command held after ack");
  idle_quiet_a: assert property (!busy |-> !bus_cmd.valid)
    else $error("bus command while engine idle");
  fill_bound_a: assert property (fill_q <= 4'h4)
    else $error("buffer overrun");
  write_data_a: assert property (bus_cmd.valid && bus_cmd.we |-> fill_q != 4'h0)
    else $error("write issued without fetched data");
  done_pulse_a: assert property (xfer_done |=> !xfer_done)
    else $error("done pulse longer than one cycle");
  done_idle_a: assert property (xfer_done |-> !busy && fill_q == 4'h0)
    else $error("done while busy or words left");

  done_c: cover property (xfer_done);
  write_c: cover property (bus_cmd.valid && bus_ack && bus_cmd.we);
  full_c: cover property (fill_q == 4'h4);
endmodule : dcp_top_chk

bind dcp_top dcp_top_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy(busy),
  .xfer_done(xfer_done));

`default_nettype wire

// file: sim/dcp_top_tb_top.sv
// self-checking bench for the dma channel parameter block
`timescale 1ns/1ps
`default_nettype none

module dcp_top_tb_top;
  logic                  clk, rst, reg_wr, reg_rd, bus_ack, busy, xfer_done;
  logic [11:0]           reg_addr;
  logic [31:0]           reg_wdata, reg_rdata, bus_rdata, r, v;
  logic [63:0]           e;
  dcp_pkg::dcp_bus_cmd_t bus_cmd;
  logic [63:0]           exp_q[$];
  int                    n_mismatch, n_checks, n_done, cyc;

  dcp_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_cmd(bus_cmd),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy(busy), .xfer_done(xfer_done));
  dcp_bus_model u_bus (.clk(clk), .rst(rst), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic chk(input logic [63:0] x, input logic [63:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, x, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic wr(input int ch, input logic [7:0] off, input logic [31:0] d);
    reg_addr  <= {ch[3:0], off};
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input int ch, input logic [7:0] off, output logic [31:0] d);
    reg_addr <= {ch[3:0], off};
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask : rd

  // program, trigger and wait for one transfer, then read the setup back
  task automatic run(input int ch, input logic [15:0] cnt, input logic [1:0] ss,
                     input logic [1:0] ds, input int cut);
    logic [31:0] s, d, a;
    int          k, t, p;
    s = $urandom & 32'hFFFF_FFFC; // word aligned
    d = $urandom & 32'hFFFF_FFFC; // word aligned
    wr(ch, dcp_pkg::OFF_SRC, s);
    wr(ch, dcp_pkg::OFF_DST, d);
    wr(ch, dcp_pkg::OFF_CNT, {16'h0, cnt}); // multiple of four
    // a cut run is stopped after its first word, then restarts from the top
    for (p = (cut != 0); p >= 0; p--)
    begin
      exp_q.delete();
      for (k = 0; k < cnt / 4; k++)
      begin
        a = s + (ss == dcp_pkg::STEP_FIX ? 0 : 4 * k);
        exp_q.push_back({d + (ds == dcp_pkg::STEP_FIX ? 0 : 4 * k), ~a});
      end
      k = n_done;
      wr(ch, dcp_pkg::OFF_CTRL, 32'h0080_0001 | {ds, ss, 4'h0});
      if (p > 0)
      begin
        for (t = 0; t < 400 && exp_q.size() == cnt / 4; t++)
          @(posedge clk);
        wr(ch, dcp_pkg::OFF_CTRL, (cut == 1) ? 32'h0000_0002 : 32'h0000_0000);
        for (t = 0; t < 20 && busy !== 1'b0; t++)
          @(posedge clk);
        chk(0, busy);
        chk(k, n_done);
        rd(ch, dcp_pkg::OFF_CTRL, r);
        chk(32'h0080_0000, r);
      end
    end
    for (t = 0; t < 400 && n_done == k; t++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk(k + 1, n_done);
    chk(0, busy);
    chk(0, exp_q.size());
    rd(ch, dcp_pkg::OFF_CTRL, r);
    chk(0, r[dcp_pkg::BIT_TRIG]);
    rd(ch, dcp_pkg::OFF_SRC, r);
    chk(s, r);
    rd(ch, dcp_pkg::OFF_DST, r);
    chk(d, r);
    rd(ch, dcp_pkg::OFF_CNT, r);
    chk(cnt, r);
    $display("test transfer ch %0d bytes %0d done", ch, cnt);
  endtask : run

  // compare every word written on the bus; count done pulses
  always @(posedge clk)
  begin
    if (xfer_done === 1'b1)
      n_done++;
    if (bus_cmd.valid === 1'b1 && bus_ack === 1'b1 && bus_cmd.we === 1'b1)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 64'hX;
      chk(e, {bus_cmd.addr, bus_cmd.wdata});
    end
  end

  // cut a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  initial
  begin
    clk       = 1'b0;
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 12'h0;
    reg_wdata = 32'h0;
    void'($urandom(82));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // every register of every channel starts at zero
    for (int c = 0; c < 9; c++)
      for (int o = 0; o < 16; o += 4)
      begin
        rd(c, o[7:0], r);
        chk(0, r);
      end
    $display("test reset values done");
    // random setups read back; the count keeps its low half only
    for (int c = 0; c < 9; c++)
      for (int o = 4; o < 16; o += 4)
      begin
        v = $urandom & 32'hFFFF_FFFC;
        wr(c, o[7:0], v);
        rd(c, o[7:0], r);
        chk(o == 12 ? {16'h0, v[15:0]} : v, r);
      end
    wr(9, dcp_pkg::OFF_SRC, 32'h1234_5678);
    rd(9, dcp_pkg::OFF_SRC, r);
    chk(0, r);
    rd(0, 8'h20, r);
    chk(0, r);
    wr(2, dcp_pkg::OFF_CTRL, 32'h0000_0003);
    rd(2, dcp_pkg::OFF_CTRL, r);
    chk(32'h1, r);
    $display("test register access done");
    run(0, 16'h0020, dcp_pkg::STEP_INC, dcp_pkg::STEP_INC, 0);
    run(8, 16'h000C, dcp_pkg::STEP_FIX, dcp_pkg::STEP_INC, 0);
    run(4, 16'h0004, dcp_pkg::STEP_INC, dcp_pkg::STEP_FIX, 0);
    run(3, 16'h0000, dcp_pkg::STEP_FIX, dcp_pkg::STEP_FIX, 0);
    run(5, 16'h0040, dcp_pkg::STEP_INC, dcp_pkg::STEP_INC, 1);
    run(6, 16'h0040, dcp_pkg::STEP_INC, dcp_pkg::STEP_INC, 2);
    conclude();
  end
endmodule : dcp_top_tb_top

`default_nettype wire
